/* hw/cip_pkg.sv */
// Constants, types and register map of the current input data path.
// Assumes a single 40 MHz clock and an APB master for register access.
package cip_pkg;

    // Widths
    localparam int ADC_W = 12;               // Converter resolution
    localparam int PD_W  = 16;               // Process data width
    localparam logic [ADC_W-1:0] ADC_LIMIT = 12'hFFF; // Limit stop code

    // Register indices, byte address is four times the index
    localparam logic [5:0] IDX_RAW      = 6'h00;
    localparam logic [5:0] IDX_CAL_OFF  = 6'h11;
    localparam logic [5:0] IDX_CAL_GAIN = 6'h12;
    localparam logic [5:0] IDX_MFR_OFF  = 6'h13;
    localparam logic [5:0] IDX_MFR_GAIN = 6'h14;
    localparam logic [5:0] IDX_FEATURE  = 6'h20;
    localparam logic [5:0] IDX_USR_OFF  = 6'h21;
    localparam logic [5:0] IDX_USR_GAIN = 6'h22;
    localparam logic [5:0] IDX_STATUS   = 6'h28;
    localparam logic [5:0] IDX_MASK     = 6'h29;
    localparam logic [5:0] IDX_PDATA    = 6'h2A;

    // Feature register fields
    localparam int FT_MFR_EN = 0;            // Manufacturer scaling
    localparam int FT_USR_EN = 1;            // User scaling
    localparam int FT_FMT_LO = 2;            // Output format, two bits
    localparam logic [15:0] FEATURE_RST = 16'h0001;

    // Status bits
    localparam int ST_WDOG  = 0;             // Watchdog overflow
    localparam int ST_LIMIT = 1;             // Converter limit reached
    localparam int ST_SMPL  = 2;             // New process data
    localparam int ST_W     = 3;

    // Reset values, gains are signed with eight fraction bits
    localparam logic [15:0] CAL_OFF_RST   = 16'h0000;
    localparam logic [15:0] CAL_GAIN_RST  = 16'h0100;
    localparam logic [15:0] MFR_OFF_RST0  = 16'h0000; // 0-20 mA span
    localparam logic [15:0] MFR_GAIN_RST0 = 16'h0801;
    localparam logic [15:0] MFR_OFF_RST4  = 16'hDFFF; // 4-20 mA span
    localparam logic [15:0] MFR_GAIN_RST4 = 16'h0A01;
    localparam logic [15:0] USR_OFF_RST   = 16'h0000;
    localparam logic [15:0] USR_GAIN_RST  = 16'h0100;
    localparam int          GAIN_FRAC     = 8;

    // Watchdog time
    localparam int WDOG_MS     = 100;
    localparam int CLK_HZ      = 40_000_000;
    localparam int WDOG_CYCLES = CLK_HZ / 1000 * WDOG_MS;

    // Output representations
    typedef enum logic [1:0] {
        FMT_TWOS    = 2'b00,
        FMT_SIGNMAG = 2'b01,
        FMT_VENDOR  = 2'b10
    } cip_fmt_t;

    // Process data word towards the coupler
    typedef struct packed {
        logic            valid;
        logic [PD_W-1:0] data;
    } cip_pd_t;

endpackage

/* hw/cip_data_path.sv */
// Single channel current input data path with APB register slave.
// Assumes adc_valid pulses with each converter result and pd_xfer
// pulses for each process data exchange with the coupler.
//
// Design decisions made here: the APB slave port and the placing of the registers.
module cip_data_path #(
    parameter bit SPAN_4MA    = 1'b0,                 // Span variant
    parameter int WDOG_CYCLES = cip_pkg::WDOG_CYCLES  // Watchdog length
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       adc_valid,
    input  wire logic [cip_pkg::ADC_W-1:0]  adc_code,
    input  wire logic                       pd_xfer,
    output cip_pkg::cip_pd_t                pd_out,
    output logic                            run_indicator,
    output logic                            fault_indicator,
    output logic                            irq
);
    import cip_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Clamp a wide signed value to the process data range
    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v > 34'sd32767) begin
            return 16'h7FFF;
        end else if (v < -34'sd32768) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    // Offset plus gain times input, gain with fraction bits
    function automatic logic [15:0] lin(input logic [15:0] off,
                                        input logic [15:0] gain,
                                        input logic [15:0] x);
        logic signed [31:0] p;
        p = $signed(x) * $signed(gain);
        return sat16(34'(p >>> GAIN_FRAC) + 34'($signed(off)));
    endfunction

    // Register index from a byte address
    function automatic logic [5:0] reg_idx(input logic [7:0] a);
        return a[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register state

    localparam logic [15:0] MFR_OFF_RST  =
        SPAN_4MA ? MFR_OFF_RST4 : MFR_OFF_RST0;
    localparam logic [15:0] MFR_GAIN_RST =
        SPAN_4MA ? MFR_GAIN_RST4 : MFR_GAIN_RST0;

    logic [ADC_W-1:0] raw_value_reg, next_raw;    // Last raw sample
    logic [15:0]      cal_off, next_cal_off;      // Calibration offset
    logic [15:0]      cal_gain, next_cal_gain;    // Calibration gain
    logic [15:0]      mfr_off, next_mfr_off;      // Manufacturer offset
    logic [15:0]      mfr_gain, next_mfr_gain;    // Manufacturer gain
    logic [15:0]      feature_config_reg, next_feature;
    logic [15:0]      usr_off, next_usr_off;      // User offset
    logic [15:0]      usr_gain, next_usr_gain;    // User gain
    logic [ST_W-1:0]  status, next_status;        // Sticky events
    logic [ST_W-1:0]  mask, next_mask;            // Interrupt mask
    logic [31:0]      next_prdata;
    logic             next_pready, next_pslverr;
    logic             wr_en;                      // Write takes effect
    logic [ST_W-1:0]  ev;                         // Event pulses

    ////////////////////////////////////////////////////////////////////
    // APB slave: answers in the first access cycle

    always_comb begin
        wr_en         = psel && penable && pready && pwrite;
        next_cal_off  = cal_off;
        next_cal_gain = cal_gain;
        next_mfr_off  = mfr_off;
        next_mfr_gain = mfr_gain;
        next_feature  = feature_config_reg;
        next_usr_off  = usr_off;
        next_usr_gain = usr_gain;
        next_mask     = mask;
        // Write one clears, a new event in the same cycle wins
        next_status   = status | ev;
        if (wr_en) begin
            unique case (reg_idx(paddr))
                IDX_CAL_OFF:  next_cal_off  = pwdata[15:0];
                IDX_CAL_GAIN: next_cal_gain = pwdata[15:0];
                IDX_MFR_OFF:  next_mfr_off  = pwdata[15:0];
                IDX_MFR_GAIN: next_mfr_gain = pwdata[15:0];
                IDX_FEATURE:  next_feature  = pwdata[15:0];
                IDX_USR_OFF:  next_usr_off  = pwdata[15:0];
                IDX_USR_GAIN: next_usr_gain = pwdata[15:0];
                IDX_MASK:     next_mask     = pwdata[ST_W-1:0];
                IDX_STATUS: begin
                    next_status = (status & ~pwdata[ST_W-1:0]) | ev;
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end
        // Setup phase prepares the answer for the access phase
        next_pready  = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0000_0000;
        if (psel && !penable) begin
            unique case (reg_idx(paddr))
                IDX_RAW:      next_prdata = {20'h0_0000, raw_value_reg};
                IDX_CAL_OFF:  next_prdata = {16'h0000, cal_off};
                IDX_CAL_GAIN: next_prdata = {16'h0000, cal_gain};
                IDX_MFR_OFF:  next_prdata = {16'h0000, mfr_off};
                IDX_MFR_GAIN: next_prdata = {16'h0000, mfr_gain};
                IDX_FEATURE:  next_prdata = {16'h0000, feature_config_reg};
                IDX_USR_OFF:  next_prdata = {16'h0000, usr_off};
                IDX_USR_GAIN: next_prdata = {16'h0000, usr_gain};
                IDX_STATUS:   next_prdata = {29'h0000_0000, status};
                IDX_MASK:     next_prdata = {29'h0000_0000, mask};
                IDX_PDATA:    next_prdata = {16'h0000, pd_out.data};
                default:      next_pslverr = 1'b1; // Unmapped address
            endcase
        end
    end

    // Register file and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_off            <= CAL_OFF_RST;
            cal_gain           <= CAL_GAIN_RST;
            mfr_off            <= MFR_OFF_RST;
            mfr_gain           <= MFR_GAIN_RST;
            feature_config_reg <= FEATURE_RST;
            usr_off            <= USR_OFF_RST;
            usr_gain           <= USR_GAIN_RST;
            status             <= '0;
            mask               <= '0;
            prdata             <= 32'h0000_0000;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
            irq                <= 1'b0;
        end else begin
            cal_off            <= next_cal_off;
            cal_gain           <= next_cal_gain;
            mfr_off            <= next_mfr_off;
            mfr_gain           <= next_mfr_gain;
            feature_config_reg <= next_feature;
            usr_off            <= next_usr_off;
            usr_gain           <= next_usr_gain;
            status             <= next_status;
            mask               <= next_mask;
            prdata             <= next_prdata;
            pready             <= next_pready;
            pslverr            <= next_pslverr;
            irq                <= |(status & mask);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sample path: capture, then calibrate, scale and format

    logic             smp_v;              // Raw sample just stored
    logic             next_smp_v;
    logic [15:0]      ya, y1, y2, yout;   // Chain of results
    logic [15:0]      mag;                // Magnitude for sign form
    cip_pd_t          next_pd;
    logic             next_fault;
    cip_fmt_t         fmt;

    always_comb begin
        next_raw   = adc_valid ? adc_code : raw_value_reg;
        next_smp_v = adc_valid;
        fmt        = cip_fmt_t'(feature_config_reg[FT_FMT_LO +: 2]);
        // Calibration: (raw plus offset) times gain, saturated
        ya = lin(16'h0000, cal_gain,
                 sat16(34'({4'h0, raw_value_reg}) +
                       34'($signed(cal_off))));
        y1 = lin(mfr_off, mfr_gain, ya);
        // Stage selection from the feature register
        unique case (feature_config_reg[FT_USR_EN:FT_MFR_EN])
            2'b00:   yout = ya;
            2'b01:   yout = y1;
            2'b10:   yout = lin(usr_off, usr_gain, ya);
            default: yout = lin(usr_off, usr_gain, y1);
        endcase
        y2 = yout;
        // Magnitude, full negative clamps to largest magnitude
        mag = (y2 == 16'h8000) ? 16'h7FFF :
              (y2[15] ? 16'(-$signed(y2)) : y2);
        next_pd.valid = smp_v;
        next_pd.data  = pd_out.data;
        if (smp_v) begin
            unique case (fmt)
                FMT_TWOS:    next_pd.data = y2;
                FMT_SIGNMAG: next_pd.data = {y2[15], mag[14:0]};
                // Vendor form: value above, limit flag in bit zero
                FMT_VENDOR:  next_pd.data = {y2[15:3], 2'b00,
                                             raw_value_reg == ADC_LIMIT};
                default:     next_pd.data = y2;          // Unused code
            endcase
        end
        next_fault = (raw_value_reg == ADC_LIMIT);
    end

    // Sample path registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_value_reg   <= '0;
            smp_v           <= 1'b0;
            pd_out          <= '0;
            fault_indicator <= 1'b0;
        end else begin
            raw_value_reg   <= next_raw;
            smp_v           <= next_smp_v;
            pd_out          <= next_pd;
            fault_indicator <= next_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Process data watchdog

    localparam logic [22:0] WD_LAST = 23'(WDOG_CYCLES - 1);
    logic [22:0] wd_cnt, next_wd_cnt;   // Cycles since last transfer
    logic        next_run;

    always_comb begin
        next_wd_cnt = wd_cnt;
        next_run    = run_indicator;
        if (pd_xfer) begin
            next_wd_cnt = '0;
            next_run    = 1'b1;
        end else if (wd_cnt == WD_LAST) begin
            next_run    = 1'b0;
        end else begin
            next_wd_cnt = wd_cnt + 23'h00_0001;
        end
        ev           = '0;
        ev[ST_WDOG]  = run_indicator && !pd_xfer && (wd_cnt == WD_LAST);
        ev[ST_LIMIT] = next_fault && !fault_indicator;
        ev[ST_SMPL]  = smp_v;
    end

    // Watchdog registers, run indicator on from reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt        <= '0;
            run_indicator <= 1'b1;
        end else begin
            wd_cnt        <= next_wd_cnt;
            run_indicator <= next_run;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_sample;
        adc_valid ##1 smp_v;
    endsequence

    property p_raw_store;
        @(posedge pclk) disable iff (!presetn)
        adc_valid |=> raw_value_reg == $past(adc_code);
    endproperty
    a_raw_store: assert property (p_raw_store)
        else $error("raw register missed a sample");

    property p_pd_after_sample;
        @(posedge pclk) disable iff (!presetn)
        s_sample |=> pd_out.valid;
    endproperty
    a_pd_after_sample: assert property (p_pd_after_sample)
        else $error("process data not issued two cycles after sample");

    property p_fault_on;
        @(posedge pclk) disable iff (!presetn)
        raw_value_reg == ADC_LIMIT |=> fault_indicator;
    endproperty
    a_fault_on: assert property (p_fault_on)
        else $error("fault indicator missing at limit stop");

    property p_fault_off;
        @(posedge pclk) disable iff (!presetn)
        raw_value_reg != ADC_LIMIT |=> !fault_indicator;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("fault indicator on in normal operation");

    property p_wdog_off;
        @(posedge pclk) disable iff (!presetn)
        (wd_cnt == WD_LAST && !pd_xfer) |=> !run_indicator;
    endproperty
    a_wdog_off: assert property (p_wdog_off)
        else $error("run indicator stayed on after watchdog time");

    // Falling run indicator leaves a sticky overflow flag behind
    property p_wdog_flag;
        @(posedge pclk) disable iff (!presetn)
        $fell(run_indicator) |-> status[ST_WDOG];
    endproperty
    a_wdog_flag: assert property (p_wdog_flag)
        else $error("watchdog overflow not flagged in status");

    // Rising fault indicator leaves a sticky limit flag behind
    property p_limit_flag;
        @(posedge pclk) disable iff (!presetn)
        $rose(fault_indicator) |-> status[ST_LIMIT];
    endproperty
    a_limit_flag: assert property (p_limit_flag)
        else $error("limit event not flagged in status");

    property p_run_on;
        @(posedge pclk) disable iff (!presetn)
        pd_xfer |=> run_indicator && wd_cnt == 23'h00_0000;
    endproperty
    a_run_on: assert property (p_run_on)
        else $error("transfer did not restart watchdog");

    property p_passthrough;
        @(posedge pclk) disable iff (!presetn)
        (smp_v && feature_config_reg[1:0] == 2'b00 && fmt == FMT_TWOS)
        |=> pd_out.data == $past(ya);
    endproperty
    a_passthrough: assert property (p_passthrough)
        else $error("unscaled output differs from calibrated value");

    property p_signmag;
        @(posedge pclk) disable iff (!presetn)
        (smp_v && fmt == FMT_SIGNMAG && y2[15])
        |=> pd_out.data[15] && pd_out.data[14:0] == $past(mag[14:0]);
    endproperty
    a_signmag: assert property (p_signmag)
        else $error("sign and magnitude form wrong");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        |(status & mask) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for unmasked event");

endmodule

/* tb/cip_coupler_model.sv */
// Behavioural model of the upstream coupler for the current input path.
// Assumes one clock shared with the data path and an active low reset.
module cip_coupler_model #(
    parameter int PERIOD = 20               // Cycles between exchanges
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             en,
    input  wire cip_pkg::cip_pd_t pd_in,
    output logic                  pd_xfer,
    output logic [15:0]           last_word
);
    timeunit 1ns;
    timeprecision 1ps;
    import cip_pkg::*;

    int unsigned cnt;                       // Exchange spacing counter

    ////////////////////////////////////////////////////////////////////
    // Exchange pulses while enabled, captures every delivered word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 0;
            pd_xfer   <= 1'b0;
            last_word <= 16'h0000;
        end else begin
            // Period stays far below the watchdog time
            pd_xfer <= en && (cnt == PERIOD - 1);
            cnt     <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            if (pd_in.valid) begin
                last_word <= pd_in.data;
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the current input data path.
// Assumes a 40 MHz clock, APB register access and a coupler model.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cip_pkg::*;

    localparam int WD = 50;                 // Shortened watchdog
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, pd_xfer, run_indicator;
    logic        fault_indicator, irq, adc_valid = 0, cpl_en = 1;
    logic [11:0] adc_code = 0;
    logic [15:0] cpl_word;
    cip_pd_t     pd_out, pd_out4;
    int          err_count = 0, checks = 0, cycles = 0;
    // Mirror of the settings that shape the expected output
    logic [15:0] cal_off = CAL_OFF_RST, cal_gain = CAL_GAIN_RST;
    logic [15:0] mfr_off = MFR_OFF_RST0, mfr_gain = MFR_GAIN_RST0;
    logic [15:0] usr_off = USR_OFF_RST, usr_gain = USR_GAIN_RST;
    logic [15:0] feat = FEATURE_RST;

    cip_data_path #(.SPAN_4MA(1'b0), .WDOG_CYCLES(WD)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid),
        .adc_code(adc_code), .pd_xfer(pd_xfer), .pd_out(pd_out),
        .run_indicator(run_indicator), .fault_indicator(fault_indicator),
        .irq(irq));
    // Second span variant sees the same traffic
    cip_data_path #(.SPAN_4MA(1'b1), .WDOG_CYCLES(WD)) dut_u_span4 (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .adc_valid(adc_valid),
        .adc_code(adc_code), .pd_xfer(pd_xfer), .pd_out(pd_out4),
        .run_indicator(), .fault_indicator(), .irq());
    cip_coupler_model #(.PERIOD(20)) cpl_u (
        .pclk(pclk), .presetn(presetn), .en(cpl_en), .pd_in(pd_out),
        .pd_xfer(pd_xfer), .last_word(cpl_word));

    ////////////////////////////////////////////////////////////////////
    // Clock, hang guard and verdict
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Compare tasks, words and single bits
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // APB master: setup, access held until pready seen at an edge
    task automatic apb(input logic wr_n, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_n;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chkb("pready", 1'b1, pready);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        apb(1'b1, {idx, 2'b00}, {16'h0000, d});
    endtask
    task automatic rdchk(input string nm, input logic [5:0] idx,
                         input logic [31:0] e);
        apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
        chk(nm, e, rd);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Reference arithmetic, saturated to signed sixteen bits
    function automatic logic [15:0] sat(input longint v);
        if (v > 32767) return 16'h7FFF;
        if (v < -32768) return 16'h8000;
        return v[15:0];
    endfunction
    function automatic logic [15:0] lin(input logic [15:0] off, g, x);
        return sat(longint'($signed(off)) +
                   ((longint'($signed(g)) * longint'($signed(x))) >>> 8));
    endfunction
    function automatic logic [15:0] expect_pd(input logic [11:0] raw);
        logic [15:0] y;
        y = lin(16'h0000, cal_gain,
                sat(longint'(raw) + longint'($signed(cal_off))));
        if (feat[FT_MFR_EN]) y = lin(mfr_off, mfr_gain, y);
        if (feat[FT_USR_EN]) y = lin(usr_off, usr_gain, y);
        if (feat[3:2] == 2'b01 && y[15]) begin
            y = (y == 16'h8000) ? 16'hFFFF : {1'b1, 15'(16'h0000 - y)};
        end else if (feat[3:2] == 2'b10) begin
            y = {y[15:3], 2'b00, raw == 12'hFFF};
        end
        return y;
    endfunction

    // One converter sample, word checked in the cycle in which it stands
    task automatic smp(input logic [11:0] code);
        logic [15:0] e;
        e = expect_pd(code);
        @(posedge pclk);
        adc_valid <= 1'b1;
        adc_code  <= code;
        @(posedge pclk);
        adc_valid <= 1'b0;
        @(posedge pclk);
        #1;
        chkb("pd_valid", 1'b1, pd_out.valid);
        chk("pd_data", 32'(e), 32'(pd_out.data));
        chkb("fault", code == 12'hFFF, fault_indicator);
        @(posedge pclk);
        #1;
        chk("coupler_word", 32'(e), 32'(cpl_word));
        chkb("pd_valid_end", 1'b0, pd_out.valid);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("feature", IDX_FEATURE, 32'h0000_0001);
        rdchk("cal_gain", IDX_CAL_GAIN, 32'h0000_0100);
        rdchk("mfr_off", IDX_MFR_OFF, 32'(MFR_OFF_RST0));
        rdchk("mfr_gain", IDX_MFR_GAIN, 32'(MFR_GAIN_RST0));
        rdchk("usr_gain", IDX_USR_GAIN, 32'h0000_0100);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chkb("slverr", 1'b1, err);
        // Span ends and middle, limit stop, then a normal code
        smp(12'h000);
        chk("span_bottom", 32'h0000_0000, 32'(pd_out.data));
        smp(12'h7FF);
        chk("span_mid", 32'h0000_3FFF, 32'(pd_out.data));
        smp(12'hFFF);
        chk("span_top", 32'h0000_7FFF, 32'(pd_out.data));
        chk("span4_top", 32'h0000_7FFF, 32'(pd_out4.data));
        rdchk("raw", IDX_RAW, 32'h0000_0FFF);
        smp(12'h333);
        chk("span4_zero", 32'h0, 32'(pd_out4.data));
        wr(IDX_RAW, 16'h0123);
        rdchk("raw_ro", IDX_RAW, 32'h0000_0333);
        // Unmasked limit event raises the interrupt, a write one to status clears it
        wr(IDX_MASK, 16'h0002);
        repeat (2) @(posedge pclk);
        #1 chkb("irq_set", 1'b1, irq);
        rdchk("status", IDX_STATUS, 32'h0000_0006);
        wr(IDX_STATUS, 16'h0002);
        repeat (2) @(posedge pclk);
        #1 chkb("irq_clr", 1'b0, irq);
        wr(IDX_MASK, 16'h0000);
        // All four combinations of the scaling stages
        usr_off  = 16'h0064;
        usr_gain = 16'h0200;
        wr(IDX_USR_OFF, usr_off);
        wr(IDX_USR_GAIN, usr_gain);
        for (int f = 0; f < 4; f++) begin
            feat = 16'(f);
            wr(IDX_FEATURE, feat);
            smp(12'h3E8);
        end
        // Output representations of a negative value
        cal_off = 16'hFF9C;
        wr(IDX_CAL_OFF, cal_off);
        for (int m = 0; m < 4; m++) begin
            feat = 16'(m << 2);
            wr(IDX_FEATURE, feat);
            smp(12'h000);
        end
        // Saturation at both ends, and the full negative magnitude
        feat     = 16'h0000;
        cal_gain = 16'h7FFF;
        wr(IDX_FEATURE, feat);
        wr(IDX_CAL_GAIN, cal_gain);
        smp(12'hFF0);
        cal_off  = 16'h8000;
        cal_gain = 16'h0200;
        wr(IDX_CAL_OFF, cal_off);
        wr(IDX_CAL_GAIN, cal_gain);
        smp(12'h000);
        feat = 16'h0004;
        wr(IDX_FEATURE, feat);
        smp(12'h000);
        // Watchdog: coupler goes silent, then resumes
        chkb("run_on", 1'b1, run_indicator);
        cpl_en <= 1'b0;
        repeat (25) @(posedge pclk);
        #1 chkb("run_early", 1'b1, run_indicator);
        repeat (35) @(posedge pclk);
        #1 chkb("run_off", 1'b0, run_indicator);
        apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0000_0000);
        chkb("wdog_flag", 1'b1, rd[ST_WDOG]);
        cpl_en <= 1'b1;
        repeat (25) @(posedge pclk);
        #1 chkb("run_back", 1'b1, run_indicator);
        conclude();
    end
endmodule
